/* File: design/bcs_swap.v */
// Boot cluster swap remapper between CPU addressing and the flash array
`timescale 1ns/1ns
`include "bcs_defs.vh"

module bcs_swap
#(
    parameter ADDR_W = `BCS_ADDR_W
)
(
    clk,
    nrst,
    cpu_addr,
    nv_flag,
    set_info_wr,
    set_info_val,
    flash_addr,
    swap_active,
    boot_flag
);
    input  wire              clk;
    input  wire              nrst;
    input  wire [ADDR_W-1:0] cpu_addr;
    input  wire              nv_flag;
    input  wire              set_info_wr;
    input  wire              set_info_val;
    output reg  [ADDR_W-1:0] flash_addr;
    output reg               swap_active;
    output wire              boot_flag;

    // Swap selector phases after reset
    localparam ST_LOAD = 1'b0;
    localparam ST_RUN  = 1'b1;
    localparam HI_W    = ADDR_W - `BCS_CLUSTER_BIT - 1;

    reg               state_reg;
    reg               state_next;
    reg               swap_active_next;
    wire              in_boot;
    wire              flip;
    wire [ADDR_W-1:0] remap_addr;

    bcs_flag_cell bcs_flag_cell_i
    (
        .clk          (clk),
        .nrst         (nrst),
        .nv_flag      (nv_flag),
        .set_info_wr  (set_info_wr),
        .set_info_val (set_info_val),
        .flag_out     (boot_flag)
    );

    // R04 flag caught once after reset release
    // Later flag writes wait for the next reset, so fetch never jumps
    always @*
    begin
        state_next       = state_reg;
        swap_active_next = swap_active;
        case (state_reg)
            ST_LOAD:
            begin
                state_next       = ST_RUN;
                swap_active_next = boot_flag;
            end
            ST_RUN:
            begin
                state_next       = ST_RUN;
                swap_active_next = swap_active;
            end
            default:
            begin
                state_next       = ST_LOAD;
                swap_active_next = 1'b0;
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            state_reg   <= ST_LOAD;
            swap_active <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            swap_active <= swap_active_next;
        end
    end

    // R01 only the two 4 KB clusters take part
    assign in_boot = (cpu_addr[ADDR_W-1:`BCS_CLUSTER_BIT+1] ==
                      {HI_W{1'b0}});
    assign flip    = in_boot & swap_active;

    // R02 R03 R08 only the cluster bit flips
    genvar b;
    generate
        for (b = 0; b < ADDR_W; b = b + 1)
        begin : g_bit
            if (b == `BCS_CLUSTER_BIT)
            begin : g_flip
                assign remap_addr[b] = cpu_addr[b] ^ flip;
            end
            else
            begin : g_keep
                assign remap_addr[b] = cpu_addr[b];
            end
        end
    endgenerate

    always @(posedge clk)
    begin
        if (!nrst)
            flash_addr <= {ADDR_W{1'b0}};
        else
            flash_addr <= remap_addr;
    end
endmodule // bcs_swap

/* File: design/bcs_defs.vh */
// Constants for the boot cluster swap address remapper
//
// Contract
// R01: The boot region is two clusters of 4 KB each, swapped as whole units.
// R02: With no swap in effect, cluster 0 is decoded at 0000H to 0FFFH.
// R03: With no swap in effect, cluster 1 is decoded at 1000H to 1FFFH.
// R04: A reset with the boot flag set maps cluster 1 onto 0000H to 0FFFH.
// R05: The swap choice survives power loss and steers the next reset.
// R06: The set-information path can both set and clear the swap choice.
// R07: Software fills and checks cluster 1 before setting the swap.
// R08: While swapped, cluster 0 is decoded at 1000H to 1FFFH.
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH

`define BCS_ADDR_W     16
`define BCS_CLUSTER_W  12
`define BCS_CLUSTER_BIT 12
`define BCS_BOOT_HI_W  3
`define BCS_BOOT_HI    3'h0
`define BCS_FLAG_RST   1'b0

`endif

/* File: design/bcs_flag_cell.v */
// Persistent boot flag cell, fed by the set-information path
`timescale 1ns/1ns
`include "bcs_defs.vh"

module bcs_flag_cell
(
    clk,
    nrst,
    nv_flag,
    set_info_wr,
    set_info_val,
    flag_out
);
    input  wire clk;
    input  wire nrst;
    input  wire nv_flag;
    input  wire set_info_wr;
    input  wire set_info_val;
    output wire flag_out;

    reg  stored_reg;
    reg  loaded_reg;

    // R05 nonvolatile value reloads
    // Cell holds flash state; nv_flag is its power-up contents
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            loaded_reg <= 1'b0;
            stored_reg <= `BCS_FLAG_RST;
        end
        else if (!loaded_reg)
        begin
            loaded_reg <= 1'b1;
            stored_reg <= set_info_wr ? set_info_val : nv_flag;
        end
        // R06 set and clear
        else if (set_info_wr)
        begin
            stored_reg <= set_info_val;
        end
    end

    assign flag_out = loaded_reg ? stored_reg : nv_flag;
endmodule // bcs_flag_cell

/* File: bench/bcs_swap_props.sv */
// Boot swap port checks
`timescale 1ns/1ns
module bcs_swap_chk (
    input wire clk,
    input wire nrst,
    input wire [15:0] cpu_addr,
    input wire set_info_wr,
    input wire set_info_val,
    input wire [15:0] flash_addr,
    input wire swap_active,
    input wire boot_flag
);
    logic [17:0] p_reg;
    always @(posedge clk) p_reg<={p_reg[16],nrst,cpu_addr};
    // Two edges out of reset before maps count
    wire u=&p_reg[17:16], s=swap_active;
    wire [15:0] p=p_reg[15:0];
    wire low=p[15:13]==0;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Second edge after release, then every later one
    sequence s_woken;
        p_reg[17:16]==2'b01;
    endsequence
    sequence s_settled;
        u;
    endsequence
    AST_HOME: assert property
        (u&&!(s&&low)|->flash_addr==p) else $error("map");
    AST_SWAP: assert property
        (u&&s&&low|->flash_addr==(p^16'h1000)) else $error("swap");
    AST_BOOT: assert property
        (s_woken|->s==$past(boot_flag)) else $error("boot");
    AST_WR: assert property
        (set_info_wr|=>boot_flag==$past(set_info_val)) else $error("flag");
    AST_HOLD: assert property
        (s_settled|->$stable(swap_active)) else $error("swap moved");
    AST_KEEP: assert property
        (s_settled ##0 !set_info_wr|=>$stable(boot_flag))
        else $error("flag moved");
endmodule // bcs_swap_chk
bind bcs_swap bcs_swap_chk bcs_swap_chk_i (.*);

/* File: bench/bcs_nv_model.sv */
// Flash-held boot flag model
`timescale 1ns/1ns
module bcs_nv_model (
    input wire clk,
    input wire nrst,
    input wire boot_flag,
    output logic nv_flag=0
);
    // kept through reset; frozen while the cell is being reset
    always @(posedge clk) if (nrst) nv_flag<=boot_flag;
endmodule // bcs_nv_model

/* File: bench/bcs_swap_bench.sv */
// Boot swap bench
`timescale 1ns/1ns
module boot_cluster_swap_bench;
    logic clk=0,nrst=0,set_info_wr=0,set_info_val=0;
    logic [15:0] cpu_addr=0;
    wire [15:0] flash_addr;
    wire nv_flag,swap_active,boot_flag;
    int fails=0,checked=0;
    always #10 clk=~clk;
    bcs_swap bcs_swap_i(.*);
    bcs_nv_model bcs_nv_model_i(.*);
    task cmp(string n,logic [15:0] e,s);
        checked++;
        if(s!==e) $display("unexpected %s %h %h",n,e,s);
        fails+=s!==e;
    endtask
    task acc(logic [15:0] i,e);
        @(posedge clk) cpu_addr<=i;
        @(posedge clk) #1 cmp("flash_addr",e,flash_addr);
    endtask
    // Write flag, then reset as after power loss
    task boot(logic v);
        @(posedge clk) {set_info_wr,set_info_val}<={1'b1,v};
        @(posedge clk) set_info_wr<=0;
        #1 cmp("boot_flag",v,boot_flag);
        @(posedge clk) nrst<=0;
        repeat(6) @(posedge clk);
        nrst<=1;
        @(posedge clk) #1 cmp("swap_active",v,swap_active);
    endtask
    task t_swap;
        boot(1);
        acc(16'h0123,16'h1123);
        acc(16'h1abc,16'h0abc);
        acc(16'h2000,16'h2000);
    endtask
    task t_back;
        boot(0);
        acc(16'h0fff,16'h0fff);
        acc(16'h1abc,16'h1abc);
    endtask
    task end_of_test;
        $display("fails %0d checked %0d",fails,checked);
        if(fails==0&&checked>0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #20000 fails++;
        end_of_test;
    end
    initial
    begin
        repeat(6) @(posedge clk);
        nrst<=1;
        t_swap;
        t_back;
        end_of_test;
    end
endmodule // boot_cluster_swap_bench
